// ===== fswd_defs.svh
// timing counts, reset values and field constants of the fail-safe watchdog sequencer
// assumes a 40 MHz system clock; all long timing runs on a half-millisecond tick
`ifndef FSWD_DEFS_SVH
`define FSWD_DEFS_SVH

`define FSWD_CLK_HZ 40000000
`define FSWD_HALF_MS_CYC (`FSWD_CLK_HZ / 2000)
`define FSWD_RETRY_MS 1
`define FSWD_RSTLOW_MAX_MS 8000
`define FSWD_INIT_WIN_MS 256
`define FSWD_RST_SHORT_MS 1
`define FSWD_RST_LONG_MS 10
`define FSWD_INT_SHORT_US 1
`define FSWD_INT_LONG_US 4
`define FSWD_INT_SHORT_CYC (`FSWD_INT_SHORT_US * `FSWD_CLK_HZ / 1000000)
`define FSWD_INT_LONG_CYC (`FSWD_INT_LONG_US * `FSWD_CLK_HZ / 1000000)
`define FSWD_LFSR_SEED 8'hb2
`define FSWD_LFSR_TAPS 8'hb8
`define FSWD_WIN_DEFAULT 4'h2
`define FSWD_WD_ERR_MAX 3'h6
`define FSWD_WD_ERR_STEP 3'h2
`define FSWD_CNT_SAT 3'h7

`endif

// ===== fswd_pkg.sv
// types shared by the sequencer and its link-side command front end
// assumes nothing beyond a SystemVerilog compiler
package fswd_pkg;

   typedef enum logic [6:0] {
      fswd_st_built_in_logic_test = 7'h01,
      fswd_st_built_in_analog_test = 7'h02,
      fswd_st_rstdly = 7'h04,
      fswd_st_init = 7'h08,
      fswd_st_norm = 7'h10,
      fswd_st_low_power_off_state = 7'h20,
      fswd_st_deep = 7'h40
   } fswd_mode_t;

   typedef enum logic [2:0] {
      fswd_cmd_answer = 3'h0,
      fswd_cmd_seed = 3'h1,
      fswd_cmd_window = 3'h2,
      fswd_cmd_rstdly = 3'h3,
      fswd_cmd_inhibit = 3'h4,
      fswd_cmd_intlen = 3'h5,
      fswd_cmd_fsrel = 3'h6
   } fswd_cmd_kind_t;

   typedef struct packed {
      fswd_cmd_kind_t kind;
      logic [7:0] data;
   } fswd_cmd_t;

   typedef struct packed {
      logic prereg_undervoltage_flag;
      logic wake0;
      logic ext_reset_req;
      logic fault_present;
      logic debug_pin;
      logic built_in_logic_test_done;
      logic built_in_logic_test_ok;
      logic built_in_analog_test_done;
      logic built_in_analog_test_ok;
   } fswd_pins_t;

   typedef struct packed {
      fswd_mode_t mode;
      logic [7:0] seed;
      logic [3:0] win_code;
      logic [2:0] wd_err;
      logic [2:0] rst_err;
      logic init_phase;
      logic inhibit;
      logic debug;
   } fswd_status_t;

   typedef struct packed {
      fswd_cmd_t held;
      logic req;
      logic [1:0] ack;
      logic ready;
   } fswd_link_st_t;

endpackage : fswd_pkg

// ===== fswd_link.sv
// link-side command front end, clocked by the controller's link clock
// assumes the sequencer echoes each request toggle back on ack_tog
module fswd_link (
   input wire logic link_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input fswd_pkg::fswd_cmd_t cmd,
   output logic cmd_ready,
   output fswd_pkg::fswd_cmd_t xfer_cmd,
   output logic xfer_tog,
   input wire logic ack_tog
);

   fswd_pkg::fswd_link_st_t q;
   fswd_pkg::fswd_link_st_t d;

   always_comb begin
      d = q;
      d.ack = {q.ack[0], ack_tog};
      // held word stays still until the echo returns, so the far side samples it safely
      if (!q.ready && (q.ack[1] == q.req)) begin
         d.ready = 1'b1;
      end else if (q.ready && cmd_valid) begin
         d.held = cmd;
         d.req = ~q.req;
         d.ready = 1'b0;
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready = q.ready;
   assign xfer_cmd = q.held;
   assign xfer_tog = q.req;

endmodule : fswd_link

// ===== fswd_sequencer.sv
// fail-safe sequencing and question/answer windowed watchdog
// assumes pins arrive asynchronously and commands come in on link_clk
`include "fswd_defs.svh"

module fswd_sequencer #(
   parameter int HALF_MS_CYC = `FSWD_HALF_MS_CYC,
   parameter int RSTLOW_TICKS = 2 * `FSWD_RSTLOW_MAX_MS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input fswd_pkg::fswd_pins_t pins,
   input wire logic cmd_valid,
   input fswd_pkg::fswd_cmd_t cmd,
   output logic cmd_ready,
   output logic reset_out_n,
   output logic failsafe_out_n,
   output logic interrupt_out_n,
   output logic regulators_on,
   output logic selftest_run,
   output fswd_pkg::fswd_status_t status
);

   typedef struct packed {
      fswd_pkg::fswd_mode_t mode;
      fswd_pkg::fswd_pins_t s1;
      fswd_pkg::fswd_pins_t s2;
      logic [2:0] tog;
      logic ack;
      logic [14:0] tick;
      logic [13:0] tmr;
      logic closed;
      logic [13:0] rlow;
      logic [7:0] lfsr;
      logic [3:0] win;
      logic [2:0] wd_err;
      logic [2:0] rst_err;
      logic [7:0] int_cnt;
      logic int_n;
      logic rst_n;
      logic fs_n;
      logic regs_on;
      logic inhibit;
      logic debug;
      logic dly_long_cfg;
      logic long_dly;
      logic int_long;
      logic init_ph;
      logic st_run;
   } fswd_main_t;

   fswd_main_t q;
   fswd_main_t d;
   fswd_pkg::fswd_cmd_t xfer_cmd;
   logic xfer_tog;
   fswd_pkg::fswd_pins_t p;
   logic ev;
   logic tick;
   logic is_ans;
   logic good;
   logic cfg_ok;
   logic init_ok;
   logic wrong;
   logic ok;
   logic go_reset;
   logic [2:0] wd_nxt;
   logic [13:0] half;
   logic [13:0] dly;

   // half-window length in half-ms ticks equals the period in ms
   // fifteen periods
   function automatic logic [13:0] fswd_win_ms(input logic [3:0] code);
      logic [13:0] ms;
      ms = 14'h0003;
      case (code)
         4'h0: ms = 14'h0001;
         4'h1: ms = 14'h0002;
         4'h2: ms = 14'h0003;
         4'h3: ms = 14'h0004;
         4'h4: ms = 14'h0006;
         4'h5: ms = 14'h0008;
         4'h6: ms = 14'h000c;
         4'h7: ms = 14'h0010;
         4'h8: ms = 14'h0018;
         4'h9: ms = 14'h0020;
         4'ha: ms = 14'h0040;
         4'hb: ms = 14'h0080;
         4'hc: ms = 14'h0100;
         4'hd: ms = 14'h0200;
         4'he: ms = 14'h0400;
         default: ms = 14'h0003;
      endcase
      return ms;
   endfunction : fswd_win_ms

   function automatic logic [7:0] fswd_lfsr_step(input logic [7:0] s);
      return {s[6:0], ^(s & `FSWD_LFSR_TAPS)};
   endfunction : fswd_lfsr_step

   fswd_link u_link (
      .link_clk(link_clk),
      .rst(rst),
      .cmd_valid(cmd_valid),
      .cmd(cmd),
      .cmd_ready(cmd_ready),
      .xfer_cmd(xfer_cmd),
      .xfer_tog(xfer_tog),
      .ack_tog(q.ack)
   );

   always_comb begin
      p = q.s2;
      ev = q.tog[2] ^ q.tog[1];
      tick = (q.tick == 15'(HALF_MS_CYC - 1));
      is_ans = ev && (xfer_cmd.kind == fswd_pkg::fswd_cmd_answer);
      good = (xfer_cmd.data == ~q.lfsr);
      cfg_ok = (q.mode == fswd_pkg::fswd_st_init) || (q.mode == fswd_pkg::fswd_st_norm);
      init_ok = ev && q.init_ph;
      wrong = 1'b0;
      ok = 1'b0;
      go_reset = 1'b0;
      wd_nxt = (q.wd_err > 3'h5) ? `FSWD_CNT_SAT : q.wd_err + `FSWD_WD_ERR_STEP;
      half = fswd_win_ms(q.win);
      if (q.long_dly || q.dly_long_cfg) begin
         dly = 14'(2 * `FSWD_RST_LONG_MS);
      end else begin
         dly = 14'(2 * `FSWD_RST_SHORT_MS);
      end

      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.tog = {q.tog[1:0], xfer_tog};
      if (ev) begin
         d.ack = ~q.ack;
      end
      d.tick = tick ? 15'h0000 : q.tick + 15'h0001;
      if (q.int_cnt != 8'h00) begin
         d.int_cnt = q.int_cnt - 8'h01;
      end
      // deep off is left only on wake0, so a stale count must not bounce the next wake
      if (q.rst_n || (q.mode == fswd_pkg::fswd_st_deep)) begin
         d.rlow = 14'h0000;
      end else if (tick && (q.rlow != 14'h3fff)) begin
         d.rlow = q.rlow + 14'h0001;
      end

      if (init_ok && (xfer_cmd.kind == fswd_pkg::fswd_cmd_seed)) begin
         d.lfsr = xfer_cmd.data;
      end
      if (init_ok && (xfer_cmd.kind == fswd_pkg::fswd_cmd_rstdly)) begin
         d.dly_long_cfg = xfer_cmd.data[0];
      end
      if (init_ok && (xfer_cmd.kind == fswd_pkg::fswd_cmd_intlen)) begin
         d.int_long = xfer_cmd.data[0];
      end
      if (ev && cfg_ok && (xfer_cmd.kind == fswd_pkg::fswd_cmd_window)) begin
         d.win = xfer_cmd.data[3:0];
      end
      if (ev && cfg_ok && (xfer_cmd.kind == fswd_pkg::fswd_cmd_inhibit)) begin
         d.inhibit = xfer_cmd.data[0];
      end
      if (ev && (xfer_cmd.kind == fswd_pkg::fswd_cmd_fsrel)) begin
         if (!p.fault_present && (q.rst_err == 3'h0) && q.rst_n) begin
            d.fs_n = 1'b1;
         end
      end

      case (q.mode)
         fswd_pkg::fswd_st_built_in_logic_test: begin
            d.rst_n = 1'b0;
            d.regs_on = 1'b1;
            d.debug = p.debug_pin;
            if (p.built_in_logic_test_done) begin
               if (p.built_in_logic_test_ok) begin
                  d.mode = fswd_pkg::fswd_st_built_in_analog_test;
               end else begin
                  d.mode = fswd_pkg::fswd_st_deep;
                  d.fs_n = 1'b0;
                  d.regs_on = 1'b0;
               end
            end
         end
         fswd_pkg::fswd_st_built_in_analog_test: begin
            d.rst_n = 1'b0;
            if (p.built_in_analog_test_done) begin
               d.fs_n = q.fs_n && p.built_in_analog_test_ok;
               d.mode = fswd_pkg::fswd_st_rstdly;
               d.tmr = 14'h0000;
            end
         end
         fswd_pkg::fswd_st_rstdly: begin
            d.rst_n = 1'b0;
            if (tick && (q.tmr != 14'h3fff)) begin
               d.tmr = q.tmr + 14'h0001;
            end
            if ((q.tmr >= dly) && !p.fault_present && !p.ext_reset_req) begin
               d.rst_n = 1'b1;
               d.mode = fswd_pkg::fswd_st_init;
               d.tmr = 14'h0000;
               d.init_ph = 1'b1;
               d.long_dly = 1'b0;
            end
         end
         fswd_pkg::fswd_st_init: begin
            if (tick) begin
               d.tmr = q.tmr + 14'h0001;
            end
            if (is_ans) begin
               if (good) begin
                  ok = 1'b1;
                  d.mode = fswd_pkg::fswd_st_norm;
                  d.init_ph = 1'b0;
               end else begin
                  wrong = 1'b1;
               end
            end else if (tick && (q.tmr == 14'(2 * `FSWD_INIT_WIN_MS - 1))) begin
               wrong = 1'b1;
            end
            if (wrong && !q.debug && !q.inhibit) begin
               go_reset = 1'b1;
            end else if (wrong) begin
               d.tmr = 14'h0000;
            end
         end
         fswd_pkg::fswd_st_norm: begin
            if (q.inhibit) begin
               d.tmr = 14'h0000;
               d.closed = 1'b1;
            end else begin
               if (tick) begin
                  d.tmr = q.tmr + 14'h0001;
               end
               if (is_ans) begin
                  if (q.closed || !good) begin
                     wrong = 1'b1;
                  end else begin
                     ok = 1'b1;
                  end
               // compare with >= so a shortened window still expires
               end else if (tick && (q.tmr >= half - 14'h0001)) begin
                  if (q.closed) begin
                     d.closed = 1'b0;
                     d.tmr = 14'h0000;
                  end else begin
                     wrong = 1'b1;
                  end
               end
               if (wrong) begin
                  d.wd_err = wd_nxt;
               end
               if (wrong && (wd_nxt >= `FSWD_WD_ERR_MAX) && !q.debug) begin
                  go_reset = 1'b1;
               end
            end
         end
         fswd_pkg::fswd_st_low_power_off_state: begin
            d.rst_n = 1'b0;
            d.regs_on = 1'b0;
            if (tick) begin
               d.tmr = q.tmr + 14'h0001;
            end
            if (tick && (q.tmr == 14'(2 * `FSWD_RETRY_MS - 1))) begin
               d.regs_on = 1'b1;
               d.mode = fswd_pkg::fswd_st_built_in_logic_test;
               d.long_dly = 1'b1;
               d.fs_n = 1'b0;
            end
         end
         fswd_pkg::fswd_st_deep: begin
            d.rst_n = 1'b0;
            d.regs_on = 1'b0;
            d.fs_n = 1'b0;
            if (p.wake0) begin
               d.regs_on = 1'b1;
               d.mode = fswd_pkg::fswd_st_built_in_logic_test;
               d.long_dly = 1'b1;
            end
         end
         default: begin
            d.mode = fswd_pkg::fswd_st_deep;
         end
      endcase

      if (ok) begin
         d.lfsr = fswd_lfsr_step(q.lfsr);
         d.tmr = 14'h0000;
         d.closed = 1'b1;
         if (q.wd_err != 3'h0) begin
            d.wd_err = q.wd_err - 3'h1;
         end
      end
      if (wrong) begin
         d.tmr = 14'h0000;
         d.closed = 1'b1;
         d.int_cnt = q.int_long ? 8'(`FSWD_INT_LONG_CYC) : 8'(`FSWD_INT_SHORT_CYC);
      end
      if (cfg_ok && p.ext_reset_req && q.rst_n) begin
         go_reset = 1'b1;
      end
      if (go_reset) begin
         d.mode = fswd_pkg::fswd_st_rstdly;
         d.rst_n = 1'b0;
         d.tmr = 14'h0000;
         d.init_ph = 1'b0;
         d.wd_err = 3'h0;
         d.rst_err = (q.rst_err == `FSWD_CNT_SAT) ? q.rst_err : q.rst_err + 3'h1;
      end
      if (cfg_ok && p.prereg_undervoltage_flag) begin
         d.mode = fswd_pkg::fswd_st_low_power_off_state;
         d.rst_n = 1'b0;
         d.regs_on = 1'b0;
         d.tmr = 14'h0000;
         d.init_ph = 1'b0;
      end
      if (!q.rst_n && (q.rlow >= 14'(RSTLOW_TICKS)) && (q.mode != fswd_pkg::fswd_st_deep)) begin
         d.mode = fswd_pkg::fswd_st_deep;
         d.regs_on = 1'b0;
         d.init_ph = 1'b0;
      end
      d.int_n = (d.int_cnt == 8'h00);
      d.st_run = d.mode[0] | d.mode[1];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.mode <= fswd_pkg::fswd_st_built_in_logic_test;
         q.lfsr <= `FSWD_LFSR_SEED;
         q.win <= `FSWD_WIN_DEFAULT;
         q.int_n <= 1'b1;
         q.regs_on <= 1'b1;
         q.long_dly <= 1'b1;
         q.dly_long_cfg <= 1'b1;
         q.closed <= 1'b1;
         q.st_run <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reset_out_n = q.rst_n;
   assign failsafe_out_n = q.fs_n;
   assign interrupt_out_n = q.int_n;
   assign regulators_on = q.regs_on;
   assign selftest_run = q.st_run;
   assign status = {q.mode, q.lfsr, q.win, q.wd_err, q.rst_err, q.init_ph, q.inhibit, q.debug};

endmodule : fswd_sequencer

// ===== fswd_seq_sva.sv
// port checker for the fail-safe watchdog sequencer
// assumes it is bound onto fswd_sequencer with its timing parameters
module fswd_seq_sva #(
   parameter int HALF_MS_CYC = 4,
   parameter int RSTLOW_TICKS = 40
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input fswd_pkg::fswd_pins_t pins,
   input wire logic cmd_valid,
   input fswd_pkg::fswd_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic reset_out_n,
   input wire logic failsafe_out_n,
   input wire logic interrupt_out_n,
   input wire logic regulators_on,
   input wire logic selftest_run,
   input fswd_pkg::fswd_status_t status
);
   timeunit 1ns;
   timeprecision 1ps;
   int lp_n;
   int rl_n;
   int in_n;
   // dwell counters, since the real figures exceed any delay range
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lp_n <= 0;
         rl_n <= 0;
         in_n <= 0;
      end else begin
         lp_n <= (status.mode == fswd_pkg::fswd_st_low_power_off_state) ? lp_n + 1 : 0;
         rl_n <= (status.mode == fswd_pkg::fswd_st_rstdly) ? rl_n + 1 : 0;
         in_n <= (status.mode == fswd_pkg::fswd_st_init) ? in_n + 1 : 0;
      end
   end
   function automatic logic [7:0] step(logic [7:0] s);
      return {s[6:0], ^(s & 8'hb8)};
   endfunction : step
   sequence wake_quiet;
      !pins.wake0 [*4];
   endsequence
   sequence in_deep;
      status.mode == fswd_pkg::fswd_st_deep;
   endsequence
   sequence built_in_logic_test_bad;
      (status.mode == fswd_pkg::fswd_st_built_in_logic_test && pins.built_in_logic_test_done && !pins.built_in_logic_test_ok) [*3];
   endsequence
   deep_hold_a: assert property (@(posedge clk) disable iff (rst)
      (wake_quiet ##0 in_deep) |=> in_deep) else $error("deep off left without wake");
   deep_off_a: assert property (@(posedge clk) disable iff (rst)
      in_deep |-> !regulators_on && !reset_out_n) else $error("deep off outputs wrong");
   built_in_logic_test_fail_a: assert property (@(posedge clk) disable iff (rst)
      built_in_logic_test_bad |-> ##[1:4] in_deep) else $error("logic test failure not sent to deep");
   low_power_off_state_len_a: assert property (@(posedge clk) disable iff (rst)
      status.mode == fswd_pkg::fswd_st_low_power_off_state |-> !regulators_on && lp_n <= 6 * HALF_MS_CYC)
      else $error("low power off too long or regulators on");
   rstlow_8s_a: assert property (@(posedge clk) disable iff (rst)
      rl_n <= (RSTLOW_TICKS + 2) * HALF_MS_CYC + 8) else $error("reset held past limit");
   init_bound_a: assert property (@(posedge clk) disable iff (rst)
      in_n <= 514 * HALF_MS_CYC + 8) else $error("init phase overran");
   init_reset_a: assert property (@(posedge clk) disable iff (rst)
      status.mode == fswd_pkg::fswd_st_init |-> reset_out_n && !selftest_run)
      else $error("init phase with reset low");
   first_good_a: assert property (@(posedge clk) disable iff (rst)
      $past(status.mode) == fswd_pkg::fswd_st_init && status.mode == fswd_pkg::fswd_st_norm
      |-> status.seed == step($past(status.seed))) else $error("word not advanced");
   seed_lock_a: assert property (@(posedge clk) disable iff (rst)
      $past(status.mode) == fswd_pkg::fswd_st_norm && status.mode == fswd_pkg::fswd_st_norm
      && status.seed != $past(status.seed) |-> status.seed == step($past(status.seed)))
      else $error("word changed outside a step");
   wd_err_step_a: assert property (@(posedge clk) disable iff (rst)
      status.wd_err > $past(status.wd_err) |-> (status.wd_err == $past(status.wd_err) + 3'h2
      || status.wd_err == 3'h7) ##[0:2] !interrupt_out_n) else $error("error step wrong");
   rst_err_step_a: assert property (@(posedge clk) disable iff (rst)
      status.rst_err > $past(status.rst_err) |-> status.rst_err == $past(status.rst_err)
      + 3'h1 ##[0:2] !reset_out_n) else $error("reset count step wrong");
   link_take_a: assert property (@(posedge link_clk) disable iff (rst)
      cmd_valid && cmd_ready |=> !cmd_ready) else $error("command taken without busy");
endmodule : fswd_seq_sva

// ===== fswd_mcu_model.sv
// controller model offering commands on the link clock
// assumes the sequencer's cmd_ready handshake in the link domain
module fswd_mcu_model (
   input wire logic link_clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output fswd_pkg::fswd_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   task automatic send(input fswd_pkg::fswd_cmd_kind_t k, input logic [7:0] d, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge link_clk);
      cmd_valid <= 1'b1;
      cmd <= '{kind: k, data: d};
      do begin
         @(posedge link_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 64);
      cmd_valid <= 1'b0;
      // scrambled, so a stale word is never mistaken for live
      cmd <= '{kind: fswd_pkg::fswd_cmd_kind_t'(~k), data: ~d};
      do begin
         @(posedge link_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 128);
   endtask : send
endmodule : fswd_mcu_model

// ===== fswd_sequencer_test.sv
// self-checking bench of the fail-safe watchdog sequencer
// assumes checker and controller model compiled first; timings scaled down
module fswd_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 4;
   localparam int RLOW = 40;
   logic clk;
   logic rst;
   logic link_clk;
   fswd_pkg::fswd_pins_t pins;
   logic cmd_valid;
   fswd_pkg::fswd_cmd_t cmd;
   logic cmd_ready, reset_out_n, failsafe_out_n, interrupt_out_n, regulators_on, selftest_run;
   fswd_pkg::fswd_status_t status;
   int fail_count = 0;
   int n_compared = 0;
   int seed = 60;
   int n;
   logic [7:0] cur;
   logic [2:0] re;
   fswd_sequencer #(.HALF_MS_CYC(HALF), .RSTLOW_TICKS(RLOW)) dut (.clk(clk), .rst(rst),
      .link_clk(link_clk), .pins(pins), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .reset_out_n(reset_out_n), .failsafe_out_n(failsafe_out_n),
      .interrupt_out_n(interrupt_out_n), .regulators_on(regulators_on),
      .selftest_run(selftest_run), .status(status));
   fswd_mcu_model mcu (.link_clk(link_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
      .cmd(cmd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   task automatic report_and_stop;
      $display("compared %0d, wrong %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // n keeps the cycles waited, used for timing checks
   task automatic wait_mode(input fswd_pkg::fswd_mode_t m, input int lim);
      n = 0;
      while (status.mode !== m && n < lim) begin
         @(posedge clk);
         n++;
      end
      check(32'(status.mode), 32'(m), "mode");
   endtask : wait_mode
   function automatic logic [7:0] nxt(logic [7:0] s);
      return {s[6:0], ^(s & 8'hb8)};
   endfunction : nxt
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      pins = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({reset_out_n, failsafe_out_n, interrupt_out_n, regulators_on}, 4'h3, "rst");
      check(status.seed, 8'hb2, "default word");
      check(status.win_code, 4'h2, "default window");
      pins.built_in_logic_test_done <= 1'b1;
      wait_mode(fswd_pkg::fswd_st_deep, 20);
      repeat (20) @(posedge clk);
      check({regulators_on, reset_out_n, failsafe_out_n}, 3'h0, "deep outputs");
      // wake held, both self tests pass, no debug strap
      pins <= 9'h08f;
      wait_mode(fswd_pkg::fswd_st_built_in_logic_test, 20);
      pins.wake0 <= 1'b0;
      wait_mode(fswd_pkg::fswd_st_rstdly, 20);
      wait_mode(fswd_pkg::fswd_st_init, 300);
      check(n >= 19 * HALF, 1, "long reset delay");
      mcu.send(fswd_pkg::fswd_cmd_fsrel, 8'h00, 0);
      check(failsafe_out_n, 1'b1, "failsafe release");
      mcu.send(fswd_pkg::fswd_cmd_rstdly, 8'h00, 0);
      mcu.send(fswd_pkg::fswd_cmd_intlen, 8'h00, 2);
      for (int c = 0; c < 15; c++) begin
         mcu.send(fswd_pkg::fswd_cmd_window, 8'(c), c % 3);
         check(status.win_code, c[3:0], "window code");
      end
      mcu.send(fswd_pkg::fswd_cmd_answer, 8'h4d, 1);
      wait_mode(fswd_pkg::fswd_st_norm, 20);
      check(status.seed, nxt(8'hb2), "advanced word");
      cur = status.seed;
      mcu.send(fswd_pkg::fswd_cmd_seed, 8'($random(seed)), 0);
      check(status.seed, cur, "locked word");
      mcu.send(fswd_pkg::fswd_cmd_answer, ~cur, 0);
      check(interrupt_out_n, 1'b0, "interrupt");
      check(status.wd_err, 3'h2, "wd errors");
      while (!interrupt_out_n && n < 200) begin
         @(posedge clk);
         n++;
      end
      mcu.send(fswd_pkg::fswd_cmd_inhibit, 8'h01, 1);
      check(status.inhibit, 1'b1, "inhibit");
      mcu.send(fswd_pkg::fswd_cmd_inhibit, 8'h00, 0);
      @(posedge clk);
      pins.ext_reset_req <= 1'b1;
      wait_mode(fswd_pkg::fswd_st_rstdly, 10);
      pins.ext_reset_req <= 1'b0;
      wait_mode(fswd_pkg::fswd_st_init, 40);
      check(n <= 5 * HALF + 8, 1, "short reset delay");
      re = status.rst_err;
      wait_mode(fswd_pkg::fswd_st_rstdly, 2200);
      check(n >= 510 * HALF, 1, "open init window");
      check(status.rst_err, re + 3'h1, "reset count");
      wait_mode(fswd_pkg::fswd_st_init, 40);
      cur = 8'($random(seed));
      mcu.send(fswd_pkg::fswd_cmd_seed, cur, 0);
      check(status.seed, cur, "seeded word");
      re = status.rst_err;
      mcu.send(fswd_pkg::fswd_cmd_answer, cur, 1);
      wait_mode(fswd_pkg::fswd_st_rstdly, 20);
      check(status.rst_err, re + 3'h1, "reset count");
      wait_mode(fswd_pkg::fswd_st_init, 40);
      cur = status.seed;
      mcu.send(fswd_pkg::fswd_cmd_answer, ~cur, 0);
      wait_mode(fswd_pkg::fswd_st_norm, 20);
      check(status.seed, nxt(cur), "advanced word");
      @(posedge clk);
      pins.fault_present <= 1'b1;
      mcu.send(fswd_pkg::fswd_cmd_window, 8'h00, 0);
      wait_mode(fswd_pkg::fswd_st_rstdly, 300);
      wait_mode(fswd_pkg::fswd_st_deep, RLOW * HALF + 100);
      // wake with debug strap, fault removed, tests pass
      pins <= 9'h09f;
      wait_mode(fswd_pkg::fswd_st_built_in_logic_test, 20);
      pins.wake0 <= 1'b0;
      wait_mode(fswd_pkg::fswd_st_init, 300);
      check(status.debug, 1'b1, "debug latch");
      mcu.send(fswd_pkg::fswd_cmd_fsrel, 8'h00, 0);
      check(failsafe_out_n, 1'b0, "failsafe refused");
      pins.prereg_undervoltage_flag <= 1'b1;
      wait_mode(fswd_pkg::fswd_st_low_power_off_state, 10);
      check(regulators_on, 1'b0, "regulators off");
      pins.prereg_undervoltage_flag <= 1'b0;
      wait_mode(fswd_pkg::fswd_st_built_in_logic_test, 40);
      check(n >= HALF, 1, "retry delay");
      report_and_stop();
   end
endmodule : fswd_sequencer_test
bind fswd_sequencer fswd_seq_sva #(.HALF_MS_CYC(HALF_MS_CYC), .RSTLOW_TICKS(RSTLOW_TICKS)) chk (
   .clk, .rst, .link_clk, .pins, .cmd_valid, .cmd, .cmd_ready, .reset_out_n, .failsafe_out_n,
   .interrupt_out_n, .regulators_on, .selftest_run, .status);
